// ---- alarm_status_pkg.sv ----
package alarm_status_pkg;

  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [7:0] MONITOR_FAULT_STATUS_ADDR = 8'h71;
  localparam logic [7:0] FAST_TX_ALARM_STATUS_ADDR = 8'h72;
  localparam logic [7:0] SIGNAL_LOSS_BIAS_ALARM_STATUS_ADDR = 8'h73;
  localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ******************************************************
  // bit positions
  // ******************************************************
  // monitor_fault_status
  localparam int THIRD_HIGH_BIT = 7;
  localparam int THIRD_LOW_BIT = 6;
  localparam int FOURTH_HIGH_BIT = 5;
  localparam int FOURTH_LOW_BIT = 4;
  localparam int FAULT_PIN_STATUS_BIT = 2;
  localparam int SHUTDOWN_GATE_BIT = 1;
  localparam int FAULT_INTERRUPT_BIT = 0;
  // fast_tx_alarm_status
  localparam int HIGH_BIAS_BIT = 3;
  localparam int TX_POWER_HIGH_BIT = 1;
  localparam int TX_POWER_LOW_BIT = 0;
  // signal_loss_bias_alarm_status
  localparam int SIGNAL_LOSS_HIGH_BIT = 7;
  localparam int SIGNAL_LOSS_LOW_BIT = 6;
  localparam int BIAS_CEILING_BIT = 3;

  // number of enable mask bytes, one per alarm/warning byte
  localparam int MASK_BYTES = 8;

  typedef enum logic [1:0] {
    LOSS_CLEAR,
    LOSS_HIGH,
    LOSS_LOW
  } signal_loss_state_t;

endpackage

// ---- signal_loss_tracker.sv ----
`timescale 1ns/1ps
`default_nettype none

// ******************************************************
// hysteresis tracker for the signal loss alarms
// ******************************************************
module signal_loss_tracker
  import alarm_status_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_sample_valid,
  input wire logic [WIDTH-1:0] i_sample,
  input wire logic [WIDTH-1:0] i_upper,
  input wire logic [WIDTH-1:0] i_lower,
  output logic o_high,
  output logic o_low
);

  initial begin
    if (WIDTH < 1) begin
      $error("signal_loss_tracker: WIDTH must be at least 1");
    end
  end

  signal_loss_state_t state_reg;
  signal_loss_state_t state_next;
  logic above_upper;
  logic below_lower;

  assign above_upper = i_sample > i_upper;
  assign below_lower = i_sample < i_lower;

  always_comb begin
    state_next = state_reg;
    if (i_sample_valid) begin
      case (state_reg)
        // [RQ13] high set and hold
        LOSS_CLEAR: begin
          if (above_upper) begin
            state_next = LOSS_HIGH;
          end else if (below_lower) begin
            state_next = LOSS_LOW;
          end
        end
        LOSS_HIGH: begin
          if (below_lower) begin
            state_next = LOSS_LOW;
          end
        end
        // [RQ14] low set and hold
        LOSS_LOW: begin
          if (above_upper) begin
            state_next = LOSS_HIGH;
          end
        end
        default: begin
          state_next = LOSS_CLEAR;
        end
      endcase
    end
  end

  // [RQ4] no transmit-disable input here
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_reg <= LOSS_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_high = state_reg == LOSS_HIGH;
  assign o_low = state_reg == LOSS_LOW;

endmodule // signal_loss_tracker

`default_nettype wire

// ---- alarm_status_flags.sv ----
// Notes on behaviour
// [RQ1] third monitor high alarm: last slow result above high threshold.
// [RQ2] third monitor low alarm: last slow result below low threshold.
// [RQ3] fourth monitor high and low alarms use the same comparisons.
// [RQ4] transmit disable leaves slow monitor and signal loss alarms alone.
// [RQ5] fault pin status shows pin level after optional inversion.
// [RQ6] shutdown gate status bit follows the internal gate signal.
// [RQ7] interrupt: masked alarms and warnings, plus four unmaskable alarms.
// [RQ8] enable masks come from the eight mask bytes supplied outside.
// [RQ9] high bias alarm follows last fast comparison above threshold.
// [RQ10] transmit power high alarm follows fast comparison above threshold.
// [RQ11] transmit power low alarm follows fast comparison below threshold.
// [RQ12] transmit disable clears high bias, power and bias ceiling alarms.
// [RQ13] signal loss high sets above upper, holds until below lower.
// [RQ14] signal loss low sets below lower, holds until above upper.
// [RQ15] bias ceiling alarm: requested bias exceeds ceiling register.
// [RQ16] reserved bits read as zero.
// [RQ17] host writes to these status registers are ignored.
`timescale 1ns/1ps
`default_nettype none

module alarm_status_flags
  import alarm_status_pkg::*;
#(
  parameter int MON_WIDTH = 16,
  parameter int BIAS_WIDTH = 9
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  // slow measurement results, one valid pulse per conversion
  input wire logic i_third_valid,
  input wire logic [MON_WIDTH-1:0] i_third_monitor_input,
  input wire logic [MON_WIDTH-1:0] i_third_high_threshold,
  input wire logic [MON_WIDTH-1:0] i_third_low_threshold,
  input wire logic i_fourth_valid,
  input wire logic [MON_WIDTH-1:0] i_fourth_monitor_input,
  input wire logic [MON_WIDTH-1:0] i_fourth_high_threshold,
  input wire logic [MON_WIDTH-1:0] i_fourth_low_threshold,
  // fast comparator levels, sampled each clock
  input wire logic i_high_bias_above,
  input wire logic i_tx_power_above,
  input wire logic i_tx_power_below,
  // signal loss fast comparison of the third monitor
  input wire logic i_loss_valid,
  input wire logic [MON_WIDTH-1:0] i_loss_sample,
  input wire logic [MON_WIDTH-1:0] i_signal_loss_upper_threshold,
  input wire logic [MON_WIDTH-1:0] i_signal_loss_lower_threshold,
  // bias ceiling check
  input wire logic [BIAS_WIDTH-1:0] i_bias_request,
  input wire logic [BIAS_WIDTH-1:0] i_bias_ceiling_limit,
  input wire logic i_transmit_disable_event,
  input wire logic i_transmit_fault_pin,
  input wire logic i_transmit_fault_invert,
  input wire logic i_shutdown_gate_signal,
  // alarm and warning bytes outside this bank, with their enable masks
  input wire logic [8*MASK_BYTES-1:0] i_other_flags,
  input wire logic [8*MASK_BYTES-1:0] i_enable_masks,
  // register port
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [7:0] i_address,
  input wire logic [7:0] i_write_data,
  output logic [7:0] o_read_data,
  output logic o_read_hit,
  output logic o_transmit_fault_interrupt
);

  initial begin
    if (MON_WIDTH < 1 || BIAS_WIDTH < 1) begin
      $error("alarm_status_flags: widths must be at least 1");
    end
  end

  // ******************************************************
  // slow monitor alarms
  // ******************************************************
  logic third_high_reg;
  logic third_low_reg;
  logic fourth_high_reg;
  logic fourth_low_reg;

  // [RQ4] no transmit-disable term in these updates
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      third_high_reg <= 1'b0;
      third_low_reg <= 1'b0;
    end else if (i_third_valid) begin
      // [RQ1] strict above
      third_high_reg <= i_third_monitor_input > i_third_high_threshold;
      // [RQ2] strict below
      third_low_reg <= i_third_monitor_input < i_third_low_threshold;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      fourth_high_reg <= 1'b0;
      fourth_low_reg <= 1'b0;
    end else if (i_fourth_valid) begin
      // [RQ3] same compare sense
      fourth_high_reg <= i_fourth_monitor_input > i_fourth_high_threshold;
      fourth_low_reg <= i_fourth_monitor_input < i_fourth_low_threshold;
    end
  end

  // ******************************************************
  // fast alarms, cleared by transmit disable
  // ******************************************************
  logic high_bias_fast_alarm_reg;
  logic tx_power_high_alarm_reg;
  logic tx_power_low_alarm_reg;
  logic bias_ceiling_limit_reg;

  // a disable event takes priority over a comparison in the same cycle;
  // the alarm may set again from the next comparison
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      high_bias_fast_alarm_reg <= 1'b0;
      tx_power_high_alarm_reg <= 1'b0;
      tx_power_low_alarm_reg <= 1'b0;
      bias_ceiling_limit_reg <= 1'b0;
    end else if (i_transmit_disable_event) begin
      // [RQ12] disable clears fast
      high_bias_fast_alarm_reg <= 1'b0;
      tx_power_high_alarm_reg <= 1'b0;
      tx_power_low_alarm_reg <= 1'b0;
      bias_ceiling_limit_reg <= 1'b0;
    end else begin
      // [RQ9] high bias compare
      high_bias_fast_alarm_reg <= i_high_bias_above;
      // [RQ10] power high compare
      tx_power_high_alarm_reg <= i_tx_power_above;
      // [RQ11] power low compare
      tx_power_low_alarm_reg <= i_tx_power_below;
      // [RQ15] bias over ceiling
      bias_ceiling_limit_reg <= i_bias_request > i_bias_ceiling_limit;
    end
  end

  // ******************************************************
  // signal loss hysteresis
  // ******************************************************
  logic signal_loss_high_alarm;
  logic signal_loss_low_alarm;

  signal_loss_tracker #(
    .WIDTH(MON_WIDTH)
  ) u_loss (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_sample_valid(i_loss_valid),
    .i_sample(i_loss_sample),
    .i_upper(i_signal_loss_upper_threshold),
    .i_lower(i_signal_loss_lower_threshold),
    .o_high(signal_loss_high_alarm),
    .o_low(signal_loss_low_alarm)
  );

  // ******************************************************
  // pin and gate status
  // ******************************************************
  logic fault_pin_status_reg;
  logic shutdown_gate_reg;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      fault_pin_status_reg <= 1'b0;
      shutdown_gate_reg <= 1'b0;
    end else begin
      // [RQ5] pin level, inverted when i_transmit_fault_invert is set
      fault_pin_status_reg <= i_transmit_fault_pin ^ i_transmit_fault_invert;
      // [RQ6] gate level mirror
      shutdown_gate_reg <= i_shutdown_gate_signal;
    end
  end

  // ******************************************************
  // interrupt aggregation
  // ******************************************************
  logic [7:0] monitor_fault_flags;
  logic [7:0] fast_tx_flags;
  logic [7:0] loss_bias_flags;
  logic masked_any;
  logic unmaskable_any;
  logic interrupt_next;
  logic interrupt_reg;

  always_comb begin
    monitor_fault_flags = READ_ZERO;
    monitor_fault_flags[THIRD_HIGH_BIT] = third_high_reg;
    monitor_fault_flags[THIRD_LOW_BIT] = third_low_reg;
    monitor_fault_flags[FOURTH_HIGH_BIT] = fourth_high_reg;
    monitor_fault_flags[FOURTH_LOW_BIT] = fourth_low_reg;
    fast_tx_flags = READ_ZERO;
    fast_tx_flags[HIGH_BIAS_BIT] = high_bias_fast_alarm_reg;
    fast_tx_flags[TX_POWER_HIGH_BIT] = tx_power_high_alarm_reg;
    fast_tx_flags[TX_POWER_LOW_BIT] = tx_power_low_alarm_reg;
    loss_bias_flags = READ_ZERO;
    loss_bias_flags[SIGNAL_LOSS_HIGH_BIT] = signal_loss_high_alarm;
    loss_bias_flags[SIGNAL_LOSS_LOW_BIT] = signal_loss_low_alarm;
    loss_bias_flags[BIAS_CEILING_BIT] = bias_ceiling_limit_reg;
  end

  // [RQ8] external mask bytes
  assign masked_any = |(i_other_flags & i_enable_masks);

  // [RQ7] unmaskable alarm terms
  assign unmaskable_any = tx_power_high_alarm_reg | tx_power_low_alarm_reg
    | bias_ceiling_limit_reg | high_bias_fast_alarm_reg;

  // [RQ7] interrupt or-reduction
  assign interrupt_next = masked_any | unmaskable_any;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      interrupt_reg <= 1'b0;
    end else begin
      interrupt_reg <= interrupt_next;
    end
  end

  assign o_transmit_fault_interrupt = interrupt_reg;

  // ******************************************************
  // register read port
  // ******************************************************
  // reads are registered; the byte reflects state one cycle before
  // o_read_hit rises
  function automatic logic [7:0] read_mux(
    input logic [7:0] address,
    input logic [7:0] monitor_byte,
    input logic [7:0] fast_byte,
    input logic [7:0] loss_byte
  );
    logic [7:0] value;
    value = READ_ZERO;
    case (address)
      MONITOR_FAULT_STATUS_ADDR: value = monitor_byte;
      FAST_TX_ALARM_STATUS_ADDR: value = fast_byte;
      SIGNAL_LOSS_BIAS_ALARM_STATUS_ADDR: value = loss_byte;
      default: value = READ_ZERO;
    endcase
    return value;
  endfunction

  logic [7:0] monitor_fault_status;
  logic [7:0] read_data_reg;
  logic read_hit_reg;

  always_comb begin
    // [RQ16] reserved bits zero
    monitor_fault_status = monitor_fault_flags;
    monitor_fault_status[FAULT_PIN_STATUS_BIT] = fault_pin_status_reg;
    monitor_fault_status[SHUTDOWN_GATE_BIT] = shutdown_gate_reg;
    monitor_fault_status[FAULT_INTERRUPT_BIT] = interrupt_reg;
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      read_data_reg <= STATUS_RESET_VALUE;
      read_hit_reg <= 1'b0;
    end else if (i_read) begin
      read_data_reg <= read_mux(i_address, monitor_fault_status,
        fast_tx_flags, loss_bias_flags);
      read_hit_reg <= (i_address == MONITOR_FAULT_STATUS_ADDR)
        || (i_address == FAST_TX_ALARM_STATUS_ADDR)
        || (i_address == SIGNAL_LOSS_BIAS_ALARM_STATUS_ADDR);
    end else begin
      read_data_reg <= read_data_reg;
      read_hit_reg <= 1'b0;
    end
  end

  // [RQ17] writes have no target
  logic write_unused;
  assign write_unused = i_write & (|i_write_data);

  assign o_read_data = read_data_reg;
  assign o_read_hit = read_hit_reg;

endmodule // alarm_status_flags

`default_nettype wire

// ---- status_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************
// host on the register port
// ********************
module status_host (
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  output var logic o_read = 1'b0,
  output var logic o_write = 1'b0,
  output var logic [7:0] o_address = 8'h00,
  output var logic [7:0] o_write_data = 8'h00
);
  always @(posedge i_clock) begin
    o_read <= i_req && !i_wr;
    o_write <= i_req && i_wr;
    // idle address flips so a design that uses it while idle is exposed
    o_address <= i_req ? i_addr : ~o_address;
    o_write_data <= ~i_addr;
  end
endmodule // status_host
`default_nettype wire

// ---- alarm_status_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************
// port checker
// ********************
module alarm_status_chk (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [7:0] i_address,
  input wire logic i_high_bias_above,
  input wire logic i_tx_power_above,
  input wire logic i_tx_power_below,
  input wire logic i_transmit_disable_event,
  input wire logic i_transmit_fault_pin,
  input wire logic i_transmit_fault_invert,
  input wire logic i_shutdown_gate_signal,
  input wire logic [7:0] o_read_data,
  input wire logic o_read_hit,
  input wire logic o_transmit_fault_interrupt
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic rd71, rd72, rd73, cmp;
  assign rd71 = i_read && i_address == 8'h71;
  assign rd72 = i_read && i_address == 8'h72;
  assign rd73 = i_read && i_address == 8'h73;
  assign cmp = i_high_bias_above || i_tx_power_above || i_tx_power_below;
  // inputs steady for three edges so every pipeline stage has caught up
  sequence s_calm;
    ($stable(i_transmit_fault_pin) && $stable(i_transmit_fault_invert)
      && $stable(i_shutdown_gate_signal) && $stable(i_high_bias_above)
      && $stable(i_tx_power_above) && $stable(i_tx_power_below)
      && !i_transmit_disable_event)[*3];
  endsequence
  sequence s_txd;
    i_transmit_disable_event[*2];
  endsequence
  property p_pin;
    s_calm ##0 rd71 |=> o_read_data[2] ==
      ($past(i_transmit_fault_pin) ^ $past(i_transmit_fault_invert));
  endproperty
  property p_gate;
    s_calm ##0 rd71 |=> o_read_data[1] == $past(i_shutdown_gate_signal);
  endproperty
  property p_hb;
    s_calm ##0 rd72 |=> o_read_data[3] == $past(i_high_bias_above);
  endproperty
  property p_tph;
    s_calm ##0 rd72 |=> o_read_data[1] == $past(i_tx_power_above);
  endproperty
  property p_tpl;
    s_calm ##0 rd72 |=> o_read_data[0] == $past(i_tx_power_below);
  endproperty
  property p_txd;
    s_txd ##0 (rd72 || rd73) |=> o_read_data[3:0] == 4'h0;
  endproperty
  property p_int;
    (cmp && !i_transmit_disable_event)[*3] |-> o_transmit_fault_interrupt;
  endproperty
  property p_resv;
    (rd72 |=> (o_read_data & 8'hf4) == 8'h00) and
      (rd73 |=> (o_read_data & 8'h37) == 8'h00) and
      (rd71 |=> !o_read_data[3]);
  endproperty
  property p_wr;
    i_write && !i_read |=> !o_read_hit && $stable(o_read_data);
  endproperty
  a_pin: assert property (p_pin) else $error("fault pin bit wrong");
  a_gate: assert property (p_gate) else $error("gate bit wrong");
  a_hb: assert property (p_hb) else $error("high bias bit wrong");
  a_tph: assert property (p_tph) else $error("power high bit wrong");
  a_tpl: assert property (p_tpl) else $error("power low bit wrong");
  a_txd: assert property (p_txd) else $error("disable left alarm");
  a_int: assert property (p_int) else $error("interrupt missing");
  a_resv: assert property (p_resv) else $error("reserved bit set");
  a_wr: assert property (p_wr) else $error("write had an effect");
endmodule // alarm_status_chk
bind alarm_status_flags alarm_status_chk i_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_read(i_read),
  .i_write(i_write), .i_address(i_address),
  .i_high_bias_above(i_high_bias_above),
  .i_tx_power_above(i_tx_power_above), .i_tx_power_below(i_tx_power_below),
  .i_transmit_disable_event(i_transmit_disable_event),
  .i_transmit_fault_pin(i_transmit_fault_pin),
  .i_transmit_fault_invert(i_transmit_fault_invert),
  .i_shutdown_gate_signal(i_shutdown_gate_signal),
  .o_read_data(o_read_data), .o_read_hit(o_read_hit),
  .o_transmit_fault_interrupt(o_transmit_fault_interrupt));
`default_nettype wire

// ---- test_alarm_status_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************
// status bank bench
// ********************
module test_alarm_status_flags;
  logic clock, resetn, t3v, f4v, lv, hba, tpa, tpb, dis, pin, inv, gate;
  logic [15:0] t3, t3h, t3l, f4, f4h, f4l, ls, x;
  logic [8:0] breq, blim;
  logic [63:0] oflg, emsk;
  logic req, wr, rd, wrs, hit, intr, lh, ll;
  logic seen = 1'b0;
  logic [7:0] addr, adr, wdat, rdata;
  logic [8:0] q[$];
  int n_fail, samples_checked;
  always #50 clock = ~clock;
  alarm_status_flags i_dut (
    .i_clock(clock), .i_resetn(resetn), .i_third_valid(t3v),
    .i_third_monitor_input(t3), .i_third_high_threshold(t3h),
    .i_third_low_threshold(t3l), .i_fourth_valid(f4v),
    .i_fourth_monitor_input(f4), .i_fourth_high_threshold(f4h),
    .i_fourth_low_threshold(f4l), .i_high_bias_above(hba),
    .i_tx_power_above(tpa), .i_tx_power_below(tpb), .i_loss_valid(lv),
    .i_loss_sample(ls), .i_signal_loss_upper_threshold(16'ha000),
    .i_signal_loss_lower_threshold(16'h6000), .i_bias_request(breq),
    .i_bias_ceiling_limit(blim), .i_transmit_disable_event(dis),
    .i_transmit_fault_pin(pin), .i_transmit_fault_invert(inv),
    .i_shutdown_gate_signal(gate), .i_other_flags(oflg),
    .i_enable_masks(emsk), .i_read(rd), .i_write(wrs), .i_address(adr),
    .i_write_data(wdat), .o_read_data(rdata), .o_read_hit(hit),
    .o_transmit_fault_interrupt(intr));
  status_host i_host (.i_clock(clock), .i_req(req), .i_wr(wr),
    .i_addr(addr), .o_read(rd), .o_write(wrs), .o_address(adr),
    .o_write_data(wdat));
  function automatic logic [15:0] rnd();
    x ^= x << 7;
    x ^= x >> 9;
    x ^= x << 8;
    return x;
  endfunction
  task automatic check(input string nm, input logic [8:0] e,
      input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic access(input logic [7:0] a, input logic w,
      input logic [8:0] e);
    @(posedge clock);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    if (!w) q.push_back(e);
    @(posedge clock);
    req <= 1'b0;
  endtask
  // read data lands one edge after the design takes the strobe
  always @(posedge clock) begin
    seen <= rd;
    if (seen) check("read", q.pop_front(), {hit, rdata});
  end
  task automatic read_all();
    logic hb, ph, pl, bc, it;
    hb = hba & !dis;
    ph = tpa & !dis;
    pl = tpb & !dis;
    bc = (breq > blim) & !dis;
    it = (|(oflg & emsk)) | hb | ph | pl | bc;
    access(8'h71, 1'b0, {1'b1, t3 > t3h, t3 < t3l, f4 > f4h, f4 < f4l,
      1'b0, pin ^ inv, gate, it});
    access(8'h72, 1'b0, {5'h10, hb, 1'b0, ph, pl});
    access(8'h73, 1'b0, {1'b1, lh, ll, 2'b00, bc, 3'b000});
  endtask
  task automatic step();
    logic [15:0] v;
    @(posedge clock);
    {t3, t3h, t3l} <= {rnd(), rnd(), rnd()};
    {f4, f4h, f4l} <= {rnd(), rnd(), rnd()};
    ls <= rnd();
    oflg <= {rnd(), rnd(), rnd(), rnd()};
    emsk <= {rnd(), rnd(), rnd(), rnd()} & {rnd(), rnd(), rnd(), rnd()};
    v = rnd();
    {hba, tpa, tpb, dis, pin, inv, gate} <= v[6:0];
    breq <= v[15:7];
    v = rnd();
    blim <= v[8:0];
    {t3v, f4v, lv} <= 3'b111;
    @(posedge clock);
    {t3v, f4v, lv} <= 3'b000;
    if (ls > 16'ha000) {lh, ll} = 2'b10;
    else if (ls < 16'h6000) {lh, ll} = 2'b01;
    repeat (3) @(posedge clock);
    access(8'h71 + {6'h00, v[10:9]}, 1'b1, 9'h000);
    read_all();
  endtask
  task automatic end_of_test();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    {t3v, f4v, lv, hba, tpa, tpb, dis, pin, inv, gate, req, wr} = '0;
    {t3, t3h, t3l, f4, f4h, f4l, ls} = '0;
    {breq, blim, oflg, emsk, addr, lh, ll} = '0;
    x = 16'h000f;
    n_fail = 0;
    samples_checked = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    read_all();
    access(8'h74, 1'b0, 9'h000);
    access(8'h70, 1'b0, 9'h000);
    $display("test reset_and_map done");
    repeat (60) step();
    $display("test random_status done");
    repeat (4) @(posedge clock);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    end_of_test();
  end
endmodule // test_alarm_status_flags
`default_nettype wire
